// >>> include/nhp_pkg.sv
package nhp_pkg;

	// ----------------------------------------------------------------
	// bus widths
	// ----------------------------------------------------------------
	localparam int unsigned NHP_DATA_W = 16;             // x16 configuration data bus
	localparam int unsigned NHP_CMD_W  = 8;              // commands and addresses use the low byte

	// ----------------------------------------------------------------
	// timing (50 MHz reference clock)
	// ----------------------------------------------------------------
	localparam int unsigned NHP_CLK_MHZ      = 50;
	localparam int unsigned NHP_STROBE_NS    = 30;       // least low/high time of a strobe phase
	localparam int unsigned NHP_STROBE_CYC   = (NHP_STROBE_NS * NHP_CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  NHP_STROBE_CNT   = 4'(NHP_STROBE_CYC);

	// ----------------------------------------------------------------
	// kinds of bus cycle the user may request
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		NHP_OP_CMD   = 2'h0,   // command latch cycle
		NHP_OP_ADDR  = 2'h1,   // address latch cycle
		NHP_OP_WRITE = 2'h2,   // data write cycle
		NHP_OP_READ  = 2'h3    // data read cycle
	} nhp_op_t;

endpackage : nhp_pkg

// >>> include/nhp_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// start and done of one strobe phase, shared by the sequencer and its timer
interface nhp_tmr_if;
	logic start;   // one-cycle pulse: begin timing a phase
	logic done;    // one-cycle pulse: phase time has elapsed

	modport ctl (output start, input done);
	modport tmr (input start, output done);
endinterface : nhp_tmr_if
`default_nettype wire

// >>> src/nhp_phase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module nhp_phase_timer
	import nhp_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset_n,
	nhp_tmr_if.tmr    tmr
);

	// ----------------------------------------------------------------
	// phase counter
	// ----------------------------------------------------------------
	logic [3:0] cnt_r;     // cycles left in the phase
	logic       run_r;     // phase being timed
	logic       last_w;    // final cycle of the phase

	assign last_w   = run_r && (cnt_r == 4'h1);
	assign tmr.done = last_w;

	// load on start, count down, stop after the final cycle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_r <= 4'h0;
			run_r <= 1'b0;
		end
		else if (tmr.start)
		begin
			cnt_r <= NHP_STROBE_CNT;
			run_r <= 1'b1;
		end
		else if (run_r)
		begin
			cnt_r <= cnt_r - 4'h1;
			run_r <= !last_w;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	phase_len_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		tmr.start |-> ##2 tmr.done)
		else $error("phase timer did not finish in two cycles");

endmodule : nhp_phase_timer
`default_nettype wire

// >>> src/nhp_host_ctrl.sv
// Functional notes
// - busy is open drain; host pulls up
// - select low enables device bus cycles
// - command strobe marks a command cycle
// - address strobe marks an address cycle
// - strobe plus select and write low decode
// - commands and addresses on low byte only
`timescale 1ns/1ps
`default_nettype none
module nhp_host_ctrl
	import nhp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	// user request side
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic [1:0]            req_op,
	input  wire logic [NHP_DATA_W-1:0] req_data,
	input  wire logic                  req_wide,
	input  wire logic                  req_lock_n,
	input  wire logic                  req_store_n,
	input  wire logic                  req_select,
	output logic                       rsp_valid,
	output logic [NHP_DATA_W-1:0]      rsp_data,
	output logic                       dev_ready,
	// device pins
	output logic                       chip_select_n,
	output logic                       command_latch_strobe,
	output logic                       address_latch_strobe,
	output logic                       write_strobe_n,
	output logic                       output_strobe_n,
	output logic                       write_lock_n,
	output logic                       hardware_store_request_n,
	input  wire logic                  ready_busy_n,
	input  wire logic [NHP_DATA_W-1:0] dq_in,
	output logic [NHP_DATA_W-1:0]      dq_out,
	output logic                       dq_oe_n
);

	// ----------------------------------------------------------------
	// state and registers
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {NHP_IDLE, NHP_ACT, NHP_REC} nhp_state_t;

	nhp_state_t                state_r;      // sequencer state
	nhp_state_t                state_nxt;    // next sequencer state
	logic [1:0]                op_r;         // cycle in flight
	logic [NHP_DATA_W-1:0]     dout_r;       // data driven to the device
	logic [NHP_DATA_W-1:0]     rdat_r;       // captured read data
	logic                      rvld_r;       // read answer pulse
	logic                      rb_s1_r;      // busy synchroniser, first stage
	logic                      rb_s2_r;      // busy synchroniser, second stage
	logic [NHP_DATA_W-1:0]     dq_s1_r;      // data synchroniser, first stage
	logic [NHP_DATA_W-1:0]     dq_s2_r;      // data synchroniser, second stage
	logic                      sel_r;        // chip select held by user
	logic                      lock_n_r;     // write lock pin register
	logic                      store_n_r;    // store request pin register

	nhp_tmr_if tmr ();

	nhp_phase_timer u_tmr
	(
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.tmr     (tmr)
	);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic take_w;     // request accepted this cycle
	logic active_w;   // strobe asserted phase
	logic is_cmd_w;   // command cycle in flight
	logic is_adr_w;   // address cycle in flight
	logic is_wr_w;    // write-type cycle in flight
	logic is_rd_w;    // read cycle in flight
	logic [NHP_DATA_W-1:0] req_masked_w;   // request data with low-byte rule applied

	assign take_w   = req_valid && req_ready;
	assign active_w = (state_r == NHP_ACT);
	assign is_cmd_w = (op_r == NHP_OP_CMD);
	assign is_adr_w = (op_r == NHP_OP_ADDR);
	assign is_rd_w  = (op_r == NHP_OP_READ);
	assign is_wr_w  = !is_rd_w;

	// low byte only: upper lines zero for commands, addresses and x8 data
	assign req_masked_w = ((req_op == NHP_OP_WRITE) && req_wide) ? req_data
		: {8'h00, req_data[NHP_CMD_W-1:0]};

	// new cycles only while idle; the device may still refuse them when busy,
	// which the user sees on dev_ready
	assign req_ready = (state_r == NHP_IDLE);
	assign tmr.start = take_w || (active_w && tmr.done);

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// select low during every cycle and while user holds it
	assign chip_select_n = !(sel_r || (state_r != NHP_IDLE));
	// command strobe only during command cycles
	assign command_latch_strobe = (state_r != NHP_IDLE) && is_cmd_w;
	// address strobe only during address cycles
	assign address_latch_strobe = (state_r != NHP_IDLE) && is_adr_w;
	// write strobe low with latch strobe gives the decode
	assign write_strobe_n  = !(active_w && is_wr_w);
	// output strobe low only in read phase
	assign output_strobe_n = !(active_w && is_rd_w);
	// host releases the bus whenever it is reading
	assign dq_oe_n  = (state_r == NHP_IDLE) || is_rd_w;
	assign dq_out   = dout_r;
	assign rsp_data = rdat_r;
	assign rsp_valid = rvld_r;
	// write lock passed to the pin
	assign write_lock_n = lock_n_r;
	assign hardware_store_request_n = store_n_r;
	// pull-up assumed: released line reads ready
	assign dev_ready = rb_s2_r;

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	// strobe phase, then recovery phase with strobe released
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			NHP_IDLE: if (take_w) state_nxt = NHP_ACT;
			NHP_ACT:  if (tmr.done) state_nxt = NHP_REC;
			NHP_REC:  if (tmr.done) state_nxt = NHP_IDLE;
			default:  state_nxt = NHP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			state_r <= NHP_IDLE;
		else
			state_r <= state_nxt;
	end

	// ----------------------------------------------------------------
	// request capture
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			op_r   <= 2'h0;
			dout_r <= 16'h0000;
		end
		else if (take_w)
		begin
			op_r   <= req_op;
			dout_r <= req_masked_w;
		end
	end

	// static pins follow the user, registered
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sel_r     <= 1'b0;
			lock_n_r  <= 1'b0;
			store_n_r <= 1'b1;
		end
		else
		begin
			sel_r     <= req_select;
			lock_n_r  <= req_lock_n;
			store_n_r <= req_store_n;
		end
	end

	// ----------------------------------------------------------------
	// pin input synchronisers
	// ----------------------------------------------------------------
	// pin inputs synchronised first
	// busy level crosses in two flops
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rb_s1_r <= 1'b1;
			rb_s2_r <= 1'b1;
			dq_s1_r <= 16'h0000;
			dq_s2_r <= 16'h0000;
		end
		else
		begin
			rb_s1_r <= ready_busy_n;
			rb_s2_r <= rb_s1_r;
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	// read data taken at the end of the recovery phase: the second stage then
	// holds the lines as they stood in the last output strobe cycle; taking it
	// any later would return the released bus, so the answer costs two cycles
	// limitation: the device must have its data out within two clocks of the strobe
	logic rd_take_w;   // last cycle of a read's recovery phase

	assign rd_take_w = (state_r == NHP_REC) && is_rd_w && tmr.done;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdat_r <= 16'h0000;
			rvld_r <= 1'b0;
		end
		else
		begin
			rvld_r <= rd_take_w;
			if (rd_take_w)
				rdat_r <= dq_s2_r;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// command strobe
	cmd_decode_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		command_latch_strobe |-> !address_latch_strobe && !chip_select_n && output_strobe_n)
		else $error("command strobe with bad companions");
	addr_decode_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		address_latch_strobe |-> !command_latch_strobe && !chip_select_n && output_strobe_n)
		else $error("address strobe with bad companions");
	bus_turn_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		!output_strobe_n |-> dq_oe_n)
		else $error("host drives bus during read");
	wr_frame_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		$rose(write_strobe_n) |-> !chip_select_n)
		else $error("write strobe rose without select");
	sel_hold_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		take_w |=> !chip_select_n [*4])
		else $error("select dropped inside a cycle");
	low_byte_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(command_latch_strobe || address_latch_strobe) |-> dq_out[15:8] == 8'h00)
		else $error("upper byte set on command or address");
	lock_pass_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		!req_lock_n |=> !write_lock_n)
		else $error("write lock not passed");
	// busy reaches user in two cycles
	busy_sync_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		!ready_busy_n ##1 !ready_busy_n |=> !dev_ready)
		else $error("busy not seen");
	read_ans_a : assert property (@(posedge ref_clk) disable iff (!reset_n)
		(take_w && req_op == NHP_OP_READ) |-> ##5 rsp_valid)
		else $error("read answer late");

	cmd_seen_c  : cover property (@(posedge ref_clk) take_w && req_op == NHP_OP_CMD);
	addr_seen_c : cover property (@(posedge ref_clk) take_w && req_op == NHP_OP_ADDR);
	rd_seen_c   : cover property (@(posedge ref_clk) rsp_valid);
	busy_c      : cover property (@(posedge ref_clk) !dev_ready);

endmodule : nhp_host_ctrl
`default_nettype wire

// >>> testbench/nhp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// behavioural memory device on the far side of the host pins
// ----------------------------------------------------------------
module nhp_dev_model
	import nhp_pkg::*;
#(
	parameter int BUSY_NS = 400   // store time, kept short for the run
)
(
	input  wire logic                  chip_select_n,
	input  wire logic                  command_latch_strobe,
	input  wire logic                  address_latch_strobe,
	input  wire logic                  write_strobe_n,
	input  wire logic                  output_strobe_n,
	input  wire logic                  write_lock_n,
	input  wire logic                  hardware_store_request_n,
	output logic                       busy_pull,   // high: ready line pulled low
	input  wire logic [NHP_DATA_W-1:0] dq_out,
	input  wire logic                  dq_oe_n,
	output logic [NHP_DATA_W-1:0]      dq_in,       // resolved shared lines
	output logic [NHP_DATA_W-1:0]      cmd_word,    // whole bus seen in last command cycle accepted
	output logic [NHP_DATA_W-1:0]      addr_word,   // whole bus seen in last address cycle
	output logic [NHP_DATA_W-1:0]      mem_word     // one-word array
);
	// lines driven only when selected and output strobe low
	wire logic dev_drive = !chip_select_n && !output_strobe_n;
	// released lines show the inverse, so an early sample cannot pass
	assign dq_in = (!dq_oe_n && dev_drive) ? 16'hXXXX :
		!dq_oe_n ? dq_out : (dev_drive ? mem_word : ~mem_word);

	initial
	begin
		busy_pull = 1'b0;
		cmd_word  = 16'h0000;
		addr_word = 16'h0000;
		mem_word  = 16'h0F0F;
	end

	// latch on write strobe rise, busy ignores most commands
	always @(posedge write_strobe_n)
	begin
		if (!chip_select_n && command_latch_strobe && !address_latch_strobe)
		begin
			if (!busy_pull || dq_in[7:0] == 8'h70 || dq_in[7:0] == 8'hFF)
				cmd_word = dq_in;
		end
		else if (!chip_select_n && address_latch_strobe && !command_latch_strobe)
			addr_word = dq_in;
		else if (!chip_select_n && !command_latch_strobe && !address_latch_strobe && write_lock_n)
			mem_word = dq_in;
	end

	// store holds the line low, never drives it high
	always @(negedge hardware_store_request_n)
	begin
		busy_pull = 1'b1;
		#(BUSY_NS);
		busy_pull = 1'b0;
	end
endmodule : nhp_dev_model
`default_nettype wire

// >>> testbench/test_nhp_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_nhp_host_ctrl
	import nhp_pkg::*;
;
	logic                  ref_clk, reset_n, req_valid, req_ready, rsp_valid, dev_ready;
	logic                  req_wide, req_lock_n, req_store_n, req_select, busy_pull;
	logic                  chip_select_n, command_latch_strobe, address_latch_strobe;
	logic                  write_strobe_n, output_strobe_n, write_lock_n, ready_busy_n;
	logic                  hardware_store_request_n, dq_oe_n;
	logic [1:0]            req_op;
	logic [NHP_DATA_W-1:0] req_data, rsp_data, dq_in, dq_out, rd_word;
	logic [NHP_DATA_W-1:0] cmd_word, addr_word, mem_word;
	int                    errors = 0;
	int                    check_count = 0;

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// open-drain ready line with its pull-up
	assign ready_busy_n = busy_pull ? 1'b0 : 1'b1;

	nhp_host_ctrl dut (.ref_clk, .reset_n, .req_valid, .req_ready, .req_op, .req_data, .req_wide,
		.req_lock_n, .req_store_n, .req_select, .rsp_valid, .rsp_data, .dev_ready, .chip_select_n,
		.command_latch_strobe, .address_latch_strobe, .write_strobe_n, .output_strobe_n,
		.write_lock_n, .hardware_store_request_n, .ready_busy_n, .dq_in, .dq_out, .dq_oe_n);
	nhp_dev_model #(.BUSY_NS(400)) device (.chip_select_n, .command_latch_strobe,
		.address_latch_strobe, .write_strobe_n, .output_strobe_n, .write_lock_n,
		.hardware_store_request_n, .busy_pull, .dq_out, .dq_oe_n, .dq_in, .cmd_word,
		.addr_word, .mem_word);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	task automatic close_out();
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// one request: raised at a falling edge, taken at the next rising edge
	task automatic do_req(input logic [1:0] op, input logic [15:0] d, input logic wide);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (req_ready !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		req_op    = op;
		req_data  = d;
		req_wide  = wide;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		n = 0;
		while (req_ready !== 1'b1 && n < 20)
		begin
			@(negedge ref_clk);
			if (rsp_valid === 1'b1)
				rd_word = rsp_data;
			n++;
		end
		check("ready after cycle", 16'h1, 16'(req_ready));
	endtask : do_req

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check("chip_select_n", 16'h1, 16'(chip_select_n));
		check("write_lock_n", 16'h0, 16'(write_lock_n));
		check("dq_oe_n", 16'h1, 16'(dq_oe_n));
		check("dev_ready", 16'h1, 16'(dev_ready));
	endtask : t_reset

	// upper byte must be zero on command and address cycles
	task automatic t_cmd_addr();
		do_req(NHP_OP_CMD, 16'hA570, 1'b1);
		check("command word", 16'h0070, cmd_word);
		do_req(NHP_OP_ADDR, 16'hFF3C, 1'b0);
		check("address word", 16'h003C, addr_word);
	endtask : t_cmd_addr

	task automatic t_write();
		do_req(NHP_OP_WRITE, 16'h1234, 1'b1);
		check("locked array", 16'h0F0F, mem_word);
		req_lock_n = 1'b1;
		do_req(NHP_OP_WRITE, 16'h77A5, 1'b0);
		check("byte write", 16'h00A5, mem_word);
		check("write_lock_n", 16'h1, 16'(write_lock_n));
		do_req(NHP_OP_WRITE, 16'hBEEF, 1'b1);
		check("word write", 16'hBEEF, mem_word);
	endtask : t_write

	task automatic t_read();
		rd_word = 16'h0000;
		do_req(NHP_OP_READ, 16'h0000, 1'b0);
		check("read word", 16'hBEEF, rd_word);
	endtask : t_read

	// store request: busy seen, then released by the pull-up
	task automatic t_store();
		int n;
		req_store_n = 1'b0;
		n = 0;
		while (dev_ready !== 1'b0 && n < 10)
		begin
			@(negedge ref_clk);
			n++;
		end
		check("store pin", 16'h0, 16'(hardware_store_request_n));
		check("busy seen", 16'h0, 16'(dev_ready));
		// host does not block while busy; the device drops all but status and reset
		do_req(NHP_OP_CMD, 16'h0090, 1'b0);
		check("busy ignores command", 16'h0070, cmd_word);
		do_req(NHP_OP_CMD, 16'h00FF, 1'b0);
		check("busy takes reset", 16'h00FF, cmd_word);
		req_store_n = 1'b1;
		n = 0;
		while (dev_ready !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk);
			n++;
		end
		check("ready again", 16'h1, 16'(dev_ready));
	endtask : t_store

	task automatic t_select();
		req_select = 1'b1;
		do_req(NHP_OP_CMD, 16'h00FF, 1'b0);
		repeat (2) @(negedge ref_clk);
		check("held select", 16'h0, 16'(chip_select_n));
		req_select = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("standby select", 16'h1, 16'(chip_select_n));
	endtask : t_select

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		reset_n     = 1'b0;
		req_valid   = 1'b0;
		req_op      = 2'h0;
		req_data    = 16'h0000;
		req_wide    = 1'b0;
		req_lock_n  = 1'b0;
		req_store_n = 1'b1;
		req_select  = 1'b0;
		repeat (10) @(negedge ref_clk);
		t_reset();
		reset_n = 1'b1;
		t_cmd_addr();
		t_write();
		t_read();
		t_store();
		t_select();
		close_out();
	end

	// the run needs under a hundred cycles; allow 2000
	initial
	begin
		#(20 * 2000);
		errors++;
		close_out();
	end
endmodule : test_nhp_host_ctrl
`default_nettype wire
